// file: rtl/atc_pkg.sv
// Purpose: Shared constants for the analog trim configuration register bank
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word
// Notes: Printed offsets are register indices; byte address is four times the index
package atc_pkg;

  // Register indices as printed
  localparam logic [7:0] ATC_IDX_FS_A = 8'h30; // Input A full-scale code
  localparam logic [7:0] ATC_IDX_FS_B = 8'h32; // Input B full-scale code
  localparam logic [7:0] ATC_IDX_REF_BYP = 8'h38; // Reference source select
  localparam logic [7:0] ATC_IDX_TS_CTRL = 8'h3B; // Timestamp input control
  localparam logic [7:0] ATC_IDX_SERIALIZER_PREEMPHASIS = 8'h48; // Serializer pre-emphasis
  localparam logic [7:0] ATC_IDX_IN_SEL = 8'h60; // Input selector control

  // Reset values
  localparam logic [15:0] ATC_RST_FS = 16'hA000; // 800 mVPP setting
  localparam logic [7:0] ATC_RST_REF_BYP = 8'h00; // Bandgap reference
  localparam logic [7:0] ATC_RST_TS_CTRL = 8'h00; // Receiver off
  localparam logic [7:0] ATC_RST_SERIALIZER_PREEMPHASIS = 8'h00; // No pre-emphasis
  localparam logic [7:0] ATC_RST_IN_SEL = 8'h01; // Input selector default

  // Lowest recommended full-scale code
  localparam logic [15:0] ATC_FS_MIN_CODE = 16'h2000;

  // Field positions
  localparam int ATC_REF_BYP_BIT = 0; // Analog supply as reference
  localparam int ATC_TS_RECV_BIT = 0; // Timestamp receiver on
  localparam int ATC_TS_PECL_BIT = 1; // Timestamp PECL select
  localparam int ATC_PE_LEVEL_LSB = 0; // Pre-emphasis level low bit
  localparam int ATC_PE_LEVEL_W = 3; // Pre-emphasis level width
  localparam int ATC_PE_BOOST_BIT = 3; // Extra boost
  localparam int ATC_LANES = 16; // Serial output lanes

  // Bus answer latency in cycles of waitrequest
  localparam int ATC_WAIT_CYCLES = 1;

endpackage

// file: rtl/atc_reg8.sv
// Purpose: One 8-bit read-write configuration register with reset value
// Assumes: Synchronous active-high reset, byte-lane write enable
// Notes: Reserved bits are stored and read back like any other bit
`timescale 1ns/1ps
module atc_reg8 import atc_pkg::*; #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);

  logic [7:0] value_ff; // Stored register contents

  // Load on write, reset to documented value
  always_ff @(posedge clock) begin
    if (rst) begin
      value_ff <= RESET_VAL;
    end else if (wr_en) begin
      value_ff <= wr_data;
    end
  end

  assign value = value_ff;

endmodule // atc_reg8

// file: rtl/atc_regs.sv
// Purpose: Configuration register bank for a dual-input sampling converter
// Assumes: Avalon-MM slave, 32-bit data, word address in address port
// Notes: One wait cycle on every access; unmapped reads return zero
//   Full-scale codes take byte lanes 0 and 1, 8-bit registers lane 0
//   Codes below the recommended minimum are stored and only flagged
`timescale 1ns/1ps
module atc_regs import atc_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int LANES = ATC_LANES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] input_a_fullscale_code,
  output logic [15:0] input_b_fullscale_code,
  output logic reference_bypass,
  output logic timestamp_receiver_on,
  output logic timestamp_pecl_select,
  output logic [LANES*ATC_PE_LEVEL_W-1:0] serializer_preemphasis,
  output logic [LANES-1:0] preemphasis_extra_boost,
  output logic [7:0] input_selector_control,
  output logic fs_a_below_min,
  output logic fs_b_below_min
);

  // Access phase state
  typedef enum logic [0:0] {
    ATC_IDLE,
    ATC_ACK
  } atc_state_t;

  atc_state_t state_ff; // Bus phase
  atc_state_t nxt_state; // Next bus phase
  logic [15:0] fs_a_ff; // Input A full-scale code
  logic [15:0] fs_b_ff; // Input B full-scale code
  logic [31:0] rdata_ff; // Registered read data
  logic [31:0] nxt_rdata; // Read mux result
  logic req; // Any request present
  logic commit; // Access completes this edge
  logic wr_ref; // Write strobe, reference bypass
  logic wr_ts; // Write strobe, timestamp control
  logic wr_pe; // Write strobe, pre-emphasis
  logic wr_sel; // Write strobe, input selector
  logic [7:0] ref_val; // Reference bypass contents
  logic [7:0] ts_val; // Timestamp control contents
  logic [7:0] pe_val; // Pre-emphasis contents
  logic [15:0] nxt_fs_a; // Input A code after this edge
  logic [15:0] nxt_fs_b; // Input B code after this edge
  logic low_a_ff; // Input A code below minimum
  logic low_b_ff; // Input B code below minimum
  logic sel_fs_a; // Address hits input A code
  logic sel_fs_b; // Address hits input B code
  logic sel_ref; // Address hits reference bypass
  logic sel_ts; // Address hits timestamp control
  logic sel_pe; // Address hits pre-emphasis
  logic sel_in; // Address hits input selector
  logic wr_fs_a; // Write strobe, input A code
  logic wr_fs_b; // Write strobe, input B code

  // Byte-lane merge of a 16-bit register
  // Lanes 2 and 3 carry nothing for these registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Match of word address against a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'(idx);
  endfunction

  // Write strobe of an 8-bit register, low byte lane only
  function automatic logic lane0_write(input logic done,
                                       input logic is_wr,
                                       input logic [3:0] be,
                                       input logic sel);
    return done && is_wr && be[0] && sel;
  endfunction

  // Code under the recommended minimum, for the status flags
  function automatic logic below_min(input logic [15:0] code);
    return code < ATC_FS_MIN_CODE;
  endfunction

  // Request present and completion edge
  assign req = avs_read | avs_write;
  assign commit = (state_ff == ATC_ACK) && req;

  // Word decode, shared by write strobes and read mux
  assign sel_fs_a = hit(avs_address, ATC_IDX_FS_A);
  assign sel_fs_b = hit(avs_address, ATC_IDX_FS_B);
  assign sel_ref = hit(avs_address, ATC_IDX_REF_BYP);
  assign sel_ts = hit(avs_address, ATC_IDX_TS_CTRL);
  assign sel_pe = hit(avs_address, ATC_IDX_SERIALIZER_PREEMPHASIS);
  assign sel_in = hit(avs_address, ATC_IDX_IN_SEL);

  // Waitrequest high until the answer cycle
  // Idle with no request leaves it low
  assign avs_waitrequest = req && (state_ff != ATC_ACK);

  // Bus phase next state
  // Every access spends one cycle waiting and one answering
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ATC_IDLE: begin
        if (req) begin
          nxt_state = ATC_ACK;
        end
      end
      ATC_ACK: begin
        nxt_state = ATC_IDLE;
      end
      default: begin
        nxt_state = ATC_IDLE;
      end
    endcase
  end

  // Bus phase register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ATC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Full-scale write strobes, either byte lane may land
  assign wr_fs_a = commit && avs_write && sel_fs_a;
  assign wr_fs_b = commit && avs_write && sel_fs_b;

  // Next full-scale codes, byte lanes merged over the old value
  // Only the addressed code changes
  always_comb begin
    nxt_fs_a = fs_a_ff; // Hold unless written
    nxt_fs_b = fs_b_ff; // Hold unless written
    if (wr_fs_a) begin
      nxt_fs_a = merge16(fs_a_ff, avs_writedata, avs_byteenable);
    end
    if (wr_fs_b) begin
      nxt_fs_b = merge16(fs_b_ff, avs_writedata, avs_byteenable);
    end
  end

  // Input A full-scale code
  always_ff @(posedge clock) begin
    if (rst) begin
      fs_a_ff <= ATC_RST_FS;
    end else begin
      fs_a_ff <= nxt_fs_a;
    end
  end

  // Input B full-scale code
  always_ff @(posedge clock) begin
    if (rst) begin
      fs_b_ff <= ATC_RST_FS;
    end else begin
      fs_b_ff <= nxt_fs_b;
    end
  end

  // Below-minimum flags follow the code being stored
  // Registered from the next code so they move with it
  always_ff @(posedge clock) begin
    if (rst) begin
      low_a_ff <= below_min(ATC_RST_FS); // Reset code in range
      low_b_ff <= below_min(ATC_RST_FS); // Reset code in range
    end else begin
      low_a_ff <= below_min(nxt_fs_a);
      low_b_ff <= below_min(nxt_fs_b);
    end
  end

  // Byte-wide write strobes, low lane only
  assign wr_ref = lane0_write(commit, avs_write, avs_byteenable, sel_ref);
  assign wr_ts = lane0_write(commit, avs_write, avs_byteenable, sel_ts);
  assign wr_pe = lane0_write(commit, avs_write, avs_byteenable, sel_pe);
  assign wr_sel = lane0_write(commit, avs_write, avs_byteenable, sel_in);

  // Eight-bit registers keep reserved bits exactly as written
  // Reference bypass register
  atc_reg8 #(.RESET_VAL(ATC_RST_REF_BYP)) u_ref (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_ref),
    .wr_data(avs_writedata[7:0]),
    .value(ref_val)
  );

  // Timestamp control register
  atc_reg8 #(.RESET_VAL(ATC_RST_TS_CTRL)) u_ts (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_ts),
    .wr_data(avs_writedata[7:0]),
    .value(ts_val)
  );

  // Serializer pre-emphasis register
  atc_reg8 #(.RESET_VAL(ATC_RST_SERIALIZER_PREEMPHASIS)) u_pe (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_pe),
    .wr_data(avs_writedata[7:0]),
    .value(pe_val)
  );

  // Input selector register
  atc_reg8 #(.RESET_VAL(ATC_RST_IN_SEL)) u_sel (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_sel),
    .wr_data(avs_writedata[7:0]),
    .value(input_selector_control)
  );

  // Read mux, reserved bits returned as stored
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (sel_fs_a) begin
      nxt_rdata[15:0] = fs_a_ff;
    end else if (sel_fs_b) begin
      nxt_rdata[15:0] = fs_b_ff;
    end else if (sel_ref) begin
      nxt_rdata[7:0] = ref_val;
    end else if (sel_ts) begin
      nxt_rdata[7:0] = ts_val;
    end else if (sel_pe) begin
      nxt_rdata[7:0] = pe_val;
    end else if (sel_in) begin
      nxt_rdata[7:0] = input_selector_control;
    end
  end

  // Read data captured while waitrequest is high
  // Registered so readdata stands through the answer cycle
  // Reads have no side effects on any register
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && state_ff == ATC_IDLE) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;

  // Analog control outputs
  // Full-scale codes go straight out of their registers
  assign input_a_fullscale_code = fs_a_ff;
  assign input_b_fullscale_code = fs_b_ff;
  // Reference source and timestamp receiver controls
  assign reference_bypass = ref_val[ATC_REF_BYP_BIT];
  assign timestamp_receiver_on = ts_val[ATC_TS_RECV_BIT];
  assign timestamp_pecl_select = ts_val[ATC_TS_PECL_BIT];

  // Global pre-emphasis fanned out to every lane
  // One setting for all lanes, no per-lane storage
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      serializer_preemphasis[i*ATC_PE_LEVEL_W +: ATC_PE_LEVEL_W] =
        pe_val[ATC_PE_LEVEL_LSB +: ATC_PE_LEVEL_W];
      preemphasis_extra_boost[i] = pe_val[ATC_PE_BOOST_BIT];
    end
  end

  // Status flags for codes below the recommended minimum
  // Guidance only: such writes are still accepted
  assign fs_a_below_min = low_a_ff;
  assign fs_b_below_min = low_b_ff;

endmodule // atc_regs

// file: testbench/atc_regs_monitor.sv
// Purpose: Concurrent checks on the trim register bank ports
// Assumes: One wait cycle per access, word-index addresses
// Notes: Field checks follow full-width writes only
`timescale 1ns/1ps
module atc_regs_monitor import atc_pkg::*; #(
  parameter int LANES = ATC_LANES
) (
  input logic clock,
  input logic rst,
  input logic [7:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [15:0] input_a_fullscale_code,
  input logic [15:0] input_b_fullscale_code,
  input logic reference_bypass,
  input logic timestamp_receiver_on,
  input logic timestamp_pecl_select,
  input logic [LANES*ATC_PE_LEVEL_W-1:0] serializer_preemphasis,
  input logic [LANES-1:0] preemphasis_extra_boost,
  input logic [7:0] input_selector_control,
  input logic fs_a_below_min,
  input logic fs_b_below_min
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Fresh request still waiting
  sequence s_new;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Full-width write taken at one word
  sequence s_wr(a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable == 4'hF;
  endsequence
  a_one_wait: assert property (s_new |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  a_fsb_write: assert property (s_wr(8'h32) |=>
    input_b_fullscale_code == $past(avs_writedata[15:0])) else $error("input B code lost");
  a_ref_write: assert property (s_wr(8'h38) |=>
    reference_bypass == $past(avs_writedata[0])) else $error("bypass bit lost");
  a_ts_write: assert property (s_wr(8'h3B) |=>
    {timestamp_pecl_select, timestamp_receiver_on} == $past(avs_writedata[1:0]))
    else $error("timestamp bits lost");
  a_pe_write: assert property (s_wr(8'h48) |=>
    {preemphasis_extra_boost[0], serializer_preemphasis[2:0]} == $past(avs_writedata[3:0]))
    else $error("pre-emphasis bits lost");
  a_pe_lanes: assert property (serializer_preemphasis == {LANES{serializer_preemphasis[2:0]}}
    && preemphasis_extra_boost == {LANES{preemphasis_extra_boost[0]}})
    else $error("lanes disagree");
  a_sel_write: assert property (s_wr(8'h60) |=>
    input_selector_control == $past(avs_writedata[7:0])) else $error("selector lost");
  a_sel_read: assert property (avs_read && !avs_waitrequest && avs_address == 8'h60 |->
    avs_readdata == {24'h000000, input_selector_control}) else $error("selector read wrong");
  a_fsa_write: assert property (s_wr(8'h30) |=>
    input_a_fullscale_code == $past(avs_writedata[15:0])) else $error("input A code lost");
  a_low_flags: assert property (
    (fs_a_below_min == (input_a_fullscale_code < ATC_FS_MIN_CODE))
    && (fs_b_below_min == (input_b_fullscale_code < ATC_FS_MIN_CODE)))
    else $error("below-minimum flag wrong");
endmodule // atc_regs_monitor

bind atc_regs atc_regs_monitor #(.LANES(LANES)) u_mon (.*);

// file: testbench/atc_regs_bench.sv
// Purpose: Register-level self-check of the trim register bank
// Assumes: One access at a time, idle cycle between accesses
// Notes: Expected values follow the register map only
`timescale 1ns/1ps
module atc_regs_bench import atc_pkg::*; ;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, reference_bypass, timestamp_receiver_on, timestamp_pecl_select;
  logic [15:0] input_a_fullscale_code, input_b_fullscale_code, preemphasis_extra_boost;
  logic [47:0] serializer_preemphasis;
  logic [7:0] input_selector_control;
  logic fs_a_below_min, fs_b_below_min;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Word table, reset values and patterns with reserved bits set
  logic [7:0] ad [6] = '{8'h30, 8'h32, 8'h38, 8'h3B, 8'h48, 8'h60};
  logic [31:0] rv [6] = '{32'hA000, 32'hA000, 32'h0, 32'h0, 32'h0, 32'h1};
  logic [31:0] wv [6] = '{32'hFFFF, 32'h2000, 32'hA5, 32'hFE, 32'hFB, 32'h5A};

  atc_regs dut (.*);

  // Clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One access, raised after an edge, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Write, then let the stored value settle on the outputs
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    bus(1'b1, a, d, be);
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(48'(rdat), 48'(exp));
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
  endtask

  // Main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 6; i++) rd(ad[i], rv[i]);
    for (int i = 0; i < 6; i++) wr(ad[i], wv[i]);
    for (int i = 0; i < 6; i++) rd(ad[i], wv[i]);
    chk(48'({reference_bypass, timestamp_receiver_on, timestamp_pecl_select}), 48'h5);
    chk(serializer_preemphasis, {16{3'h3}});
    chk(48'(preemphasis_extra_boost), 48'hFFFF);
    chk(48'(input_selector_control), 48'h5A);
    wr(8'h3B, 32'h01);
    wr(8'h48, 32'h04);
    wr(8'h38, 32'h00);
    chk(48'({reference_bypass, timestamp_receiver_on, timestamp_pecl_select}), 48'h2);
    chk(serializer_preemphasis, {16{3'h4}});
    chk(48'(preemphasis_extra_boost), 48'h0);
    // Lane enables: none, low byte only, high byte only
    wr(8'h38, 32'h01, 4'h0);
    chk(48'(reference_bypass), 48'h0);
    wr(8'h30, 32'h1234, 4'h1);
    rd(8'h30, 32'hFF34);
    wr(8'h32, 32'h5678, 4'h2);
    rd(8'h32, 32'h5600);
    wr(8'h32, 32'h1FFF);
    chk(48'({fs_a_below_min, fs_b_below_min}), 48'h1);
    // Unmapped word leaves neighbours alone
    wr(8'h31, 32'hFFFF);
    rd(8'h31, 32'h0);
    rd(8'h30, 32'hFF34);
    // Second reset in mid-run
    do_reset();
    rd(8'h60, 32'h01);
    chk(48'(input_a_fullscale_code), 48'hA000);
    chk(48'(input_b_fullscale_code), 48'hA000);
    report_and_stop();
  end
endmodule // atc_regs_bench
